// ==== hw/usbdbg_regs.sv ====
// Top: scratch and debug-event register bank on AHB-Lite
`timescale 1ns/10ps
`default_nettype none
module usbdbg_regs
  import usbdbg_pkg::*;
(
  input wire logic MCLK,
  input wire logic SYS_RST,
  input wire logic HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [2:0] HSIZE,
  input wire logic [31:0] HWDATA,
  input wire logic HREADY,
  output logic [31:0] HRDATA,
  output logic HREADYOUT,
  output logic HRESP,
  input wire usbdbg_mon_s MON,
  input wire logic LINK_BUSY,
  output logic RXCMD_SEND,
  output usbdbg_rpt_s RXCMD_RPT,
  output logic [7:0] SCRATCH_OUT
);
  logic [7:0] scratch_q;
  logic [7:0] pwr_q;
  logic wr_pend_q;
  logic [7:0] wr_addr_q;
  logic [31:0] rdata_q;
  logic [6:0] any_edge;
  logic [6:0] rise_edge;
  logic [NUM_SRC-1:0] evt;
  logic alt_evt;
  logic [NUM_SRC-1:0] pend;

  // Address phase decode
  wire addr_valid = HSEL & HREADY & HTRANS[1];
  wire rd_take = addr_valid & ~HWRITE;
  wire wr_take = addr_valid & HWRITE;
  wire [7:0] a_idx = HADDR[9:2]; // word index; byte address is four times it
  wire hi_zero = (HADDR[31:10] == 22'h0);
  wire aligned = (HADDR[1:0] == 2'b00);
  wire addr_ok = hi_zero & aligned;
  wire [7:0] wd = HWDATA[7:0];
  wire [7:0] w_addr = wr_addr_q;
  wire wr_scr = wr_pend_q & (w_addr == ADDR_SCRATCH);
  wire wr_set = wr_pend_q & (w_addr == ADDR_SCRATCH_SET);
  wire wr_clr = wr_pend_q & (w_addr == ADDR_SCRATCH_CLR);
  wire wr_pwr = wr_pend_q & (w_addr == ADDR_PWR_CTRL);
  wire is_scr = (a_idx == ADDR_SCRATCH) | (a_idx == ADDR_SCRATCH_SET) |
                (a_idx == ADDR_SCRATCH_CLR);

  // Scratch next value: direct, set alias, clear alias
  wire [7:0] scratch_d = wr_scr ? wd :
                         wr_set ? (scratch_q | wd) :
                         wr_clr ? (scratch_q & ~wd) :
                         scratch_q;

  // Power-control next value; reserved bits kept as written
  wire [7:0] pwr_d = wr_pwr ? wd : pwr_q;

  // Read selection; a write in its data phase shows through to a read behind it
  wire [31:0] rd_mux = !addr_ok ? WORD_ZERO :
                       is_scr ? {24'h000000, scratch_d} :
                       (a_idx == ADDR_PWR_CTRL) ? {24'h000000, pwr_d} :
                       (a_idx == ADDR_EVT_STATUS) ? {26'h0000000, pend} :
                       WORD_ZERO;

  // Bus state and registers
  always_ff @(posedge MCLK) begin
    if (SYS_RST) begin
      scratch_q <= RST_SCRATCH;
      pwr_q <= RST_PWR_CTRL;
      wr_pend_q <= 1'b0;
      wr_addr_q <= 8'h00;
      rdata_q <= WORD_ZERO;
    end else begin
      scratch_q <= scratch_d;
      if (wr_pwr) begin
        pwr_q <= wd; // reserved bits stored as written
      end
      wr_pend_q <= wr_take & addr_ok;
      wr_addr_q <= a_idx;
      if (rd_take) begin
        rdata_q <= rd_mux;
      end
    end
  end

  // Enabled events per source; cause index order as the report vector
  assign evt[5] = pwr_q[BIT_SUPPLY_EN] & any_edge[6];
  assign evt[4] = pwr_q[BIT_IDFLOAT_EN] & any_edge[5];
  assign evt[3] = pwr_q[BIT_IDRES_EN] & (|any_edge[4:2]);
  assign evt[2] = pwr_q[BIT_BVALID_FALL] & any_edge[0] & ~rise_edge[0];
  assign evt[1] = pwr_q[BIT_BVALID_RISE] & rise_edge[0];
  assign evt[0] = pwr_q[BIT_STRESS_EN] & any_edge[1];
  assign alt_evt = evt[2] | evt[1];

  usbdbg_edge u_edge (
    .clk(MCLK),
    .rst(SYS_RST),
    .mon(MON),
    .any_edge(any_edge),
    .rise_edge(rise_edge)
  );

  usbdbg_pend u_pend (
    .clk(MCLK),
    .rst(SYS_RST),
    .evt(evt),
    .alt_evt(alt_evt),
    .bus_busy(LINK_BUSY),
    .send_q(RXCMD_SEND),
    .rpt_q(RXCMD_RPT),
    .pend_q(pend)
  );

  // Read data and scratch outputs from flops; zero wait states, always OKAY
  assign HRDATA = rdata_q;
  assign HREADYOUT = 1'b1;
  assign HRESP = 1'b0;
  assign SCRATCH_OUT = scratch_q;
endmodule
`default_nettype wire

// ==== hw/usbdbg_pkg.sv ====
// Package: register map, field positions, reset values and carrier types
package usbdbg_pkg;
  localparam logic [7:0] ADDR_SCRATCH = 8'h16;
  localparam logic [7:0] ADDR_SCRATCH_SET = 8'h17;
  localparam logic [7:0] ADDR_SCRATCH_CLR = 8'h18;
  localparam logic [7:0] ADDR_PWR_CTRL = 8'h3d;
  localparam logic [7:0] ADDR_EVT_STATUS = 8'h40;
  localparam logic [7:0] RST_SCRATCH = 8'h00;
  localparam logic [7:0] RST_PWR_CTRL = 8'h00;
  localparam int BIT_STRESS_EN = 0;
  localparam int BIT_SPARE_LO = 1;
  localparam int BIT_BVALID_RISE = 2;
  localparam int BIT_BVALID_FALL = 3;
  localparam int BIT_IDRES_EN = 4;
  localparam int BIT_IDFLOAT_EN = 5;
  localparam int BIT_SUPPLY_EN = 6;
  localparam int BIT_SPARE_HI = 7;
  localparam int NUM_SRC = 6;
  localparam logic [1:0] HTRANS_NONSEQ = 2'b10;
  localparam logic [31:0] WORD_ZERO = 32'h0000_0000;

  // Monitored internal signals, sampled on MCLK
  typedef struct packed {
    logic supply_input_ok_monitor;
    logic id_pin_floating;
    logic id_resistor_detect_a;
    logic id_resistor_detect_b;
    logic id_resistor_detect_c;
    logic abnormal_stress_detect;
    logic bvalid;
  } usbdbg_mon_s;

  // Report handed to the RX CMD framer
  typedef struct packed {
    logic alt_int;
    logic [NUM_SRC-1:0] cause;
  } usbdbg_rpt_s;
endpackage

// ==== hw/usbdbg_edge.sv ====
// Edge detector for the monitored signals
`timescale 1ns/10ps
`default_nettype none
module usbdbg_edge
  import usbdbg_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire usbdbg_mon_s mon,
  output logic [6:0] any_edge,
  output logic [6:0] rise_edge
);
  logic [6:0] prev_q;
  logic primed_q;

  // Hold last sample; first sample after reset reports no edge
  always_ff @(posedge clk) begin
    if (rst) begin
      prev_q <= 7'h00;
      primed_q <= 1'b0;
    end else begin
      prev_q <= mon;
      primed_q <= 1'b1;
    end
  end

  // Per-bit transition flags
  genvar i;
  generate
    for (i = 0; i < 7; i++) begin : g_bit
      assign any_edge[i] = primed_q & (mon[i] ^ prev_q[i]);
      assign rise_edge[i] = primed_q & mon[i] & ~prev_q[i];
    end
  endgenerate
endmodule
`default_nettype wire

// ==== hw/usbdbg_pend.sv ====
// Pending-report holder: events wait until the link bus is free
`timescale 1ns/10ps
`default_nettype none
module usbdbg_pend
  import usbdbg_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic [NUM_SRC-1:0] evt,
  input wire logic alt_evt,
  input wire logic bus_busy,
  output logic send_q,
  output usbdbg_rpt_s rpt_q,
  output logic [NUM_SRC-1:0] pend_q
);
  logic alt_pend_q;
  logic fire;
  assign fire = ~bus_busy & ((|pend_q) | (|evt));

  // Accumulate events; events in the send cycle join that report
  always_ff @(posedge clk) begin
    if (rst) begin
      pend_q <= '0;
      alt_pend_q <= 1'b0;
      send_q <= 1'b0;
      rpt_q <= '0;
    end else begin
      send_q <= fire;
      if (fire) begin
        rpt_q.cause <= pend_q | evt;
        rpt_q.alt_int <= alt_pend_q | alt_evt;
        pend_q <= '0;
        alt_pend_q <= 1'b0;
      end else begin
        pend_q <= pend_q | evt;
        alt_pend_q <= alt_pend_q | alt_evt;
      end
    end
  end
endmodule
`default_nettype wire

// ==== tb/usbdbg_chk.sv ====
// Checker: bus, scratch and event-report properties
`timescale 1ns/10ps
`default_nettype none
module usbdbg_chk
  import usbdbg_pkg::*;
(
  input wire logic MCLK,
  input wire logic SYS_RST,
  input wire logic HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [31:0] HWDATA,
  input wire logic [31:0] HRDATA,
  input wire usbdbg_mon_s MON,
  input wire logic LINK_BUSY,
  input wire logic RXCMD_SEND,
  input wire usbdbg_rpt_s RXCMD_RPT,
  input wire logic [7:0] SCRATCH_OUT
);
  logic take, wr_q;
  logic [7:0] a_q, en_q;
  default clocking @(posedge MCLK); endclocking
  default disable iff (SYS_RST);
  // Data-phase write tracking and enable copy
  assign take = HSEL && HTRANS[1];
  always_ff @(posedge MCLK) begin
    wr_q <= !SYS_RST && take && HWRITE;
    a_q <= HADDR[9:2];
    en_q <= SYS_RST ? 8'h00 : (wr_q && a_q == ADDR_PWR_CTRL) ? HWDATA[7:0] : en_q;
  end
  a_rst_quiet: assert property ($fell(SYS_RST) |-> !RXCMD_SEND [*4])
    else $error("report after reset");
  a_busy_hold: assert property (RXCMD_SEND |-> !$past(LINK_BUSY))
    else $error("report while busy");
  a_alt_int: assert property (RXCMD_SEND |-> RXCMD_RPT.alt_int == |RXCMD_RPT.cause[2:1])
    else $error("alt_int wrong");
  a_cause_mask: assert property (RXCMD_SEND |->
    (RXCMD_RPT.cause & ~{en_q[6:2], en_q[0]}) == 6'h00) else $error("disabled cause");
  a_stress_rpt: assert property ($changed(MON.abnormal_stress_detect) && en_q[0]
    && !LINK_BUSY |-> ##[1:3] RXCMD_SEND && RXCMD_RPT.cause[0]) else $error("stress lost");
  a_scratch_rd: assert property (take && !HWRITE && HADDR == {22'h0, ADDR_SCRATCH, 2'b00}
    |=> HRDATA == {24'h0, SCRATCH_OUT}) else $error("scratch read");
  a_set_bits: assert property (wr_q && a_q == ADDR_SCRATCH_SET |=>
    SCRATCH_OUT == ($past(SCRATCH_OUT) | $past(HWDATA[7:0]))) else $error("set alias");
  a_clr_bits: assert property (wr_q && a_q == ADDR_SCRATCH_CLR |=>
    SCRATCH_OUT == ($past(SCRATCH_OUT) & ~$past(HWDATA[7:0]))) else $error("clear alias");
  c_alt: cover property (RXCMD_SEND && RXCMD_RPT.alt_int);
  c_held: cover property (LINK_BUSY ##1 !LINK_BUSY ##[1:3] RXCMD_SEND);
  c_clr: cover property (wr_q && a_q == ADDR_SCRATCH_CLR);
endmodule
bind usbdbg_regs usbdbg_chk u_chk (.*);
`default_nettype wire

// ==== tb/usbdbg_link.sv ====
// Link controller model: holds the bus and collects reports
`timescale 1ns/10ps
`default_nettype none
module usbdbg_link
  import usbdbg_pkg::*;
(
  input wire logic clk,
  input wire logic hold,
  input wire logic send,
  input wire usbdbg_rpt_s rpt,
  output logic busy,
  output usbdbg_rpt_s got,
  output int n
);
  int cnt = 0;
  // Bus occupancy on request, report capture
  always @(posedge clk) begin
    busy <= hold;
    if (send) begin
      got <= rpt;
      cnt <= cnt + 1;
    end
  end
  assign n = cnt;
endmodule
`default_nettype wire

// ==== tb/usbdbg_regs_bench.sv ====
// Testbench: register bank and debug-event reports
`timescale 1ns/10ps
`default_nettype none
module usbdbg_regs_bench
  import usbdbg_pkg::*;
;
  logic clk = 0, rst = 1, sel = 0, wr = 0, hold = 0, rdy, busy, send, resp;
  logic [1:0] trans = 2'b00;
  logic [31:0] addr = 0, wdata = 0, rdata, rd;
  usbdbg_mon_s mon = '0;
  usbdbg_rpt_s rpt, got;
  int n, m, mismatches = 0, check_count = 0;
  // Rows: address, written byte, byte read back
  logic [23:0] rows [5] = '{24'h16a5a5, 24'h1742e7, 24'h188166, 24'h3d7d7d, 24'h20ff00};
  logic [6:0] ev [7] = '{7'h42, 7'h01, 7'h08, 7'h08, 7'h08, 7'h10, 7'h20};
  always #10 clk = ~clk;
  usbdbg_regs i_dut (.MCLK(clk), .SYS_RST(rst), .HSEL(sel), .HADDR(addr), .HTRANS(trans),
    .HWRITE(wr), .HSIZE(3'b010), .HWDATA(wdata), .HREADY(rdy), .HRDATA(rdata), .HREADYOUT(rdy),
    .HRESP(resp), .MON(mon), .LINK_BUSY(busy), .RXCMD_SEND(send), .RXCMD_RPT(rpt), .SCRATCH_OUT());
  usbdbg_link i_link (.clk(clk), .hold(hold), .send(send), .rpt(rpt), .busy(busy), .got(got),
    .n(n));
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    check_count++;
    if (s !== e) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", nm, e, s);
    end
  endtask
  // One single AHB-Lite transfer
  task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
    sel <= 1;
    trans <= HTRANS_NONSEQ;
    wr <= w;
    addr <= {22'h0, a, 2'b00};
    do @(posedge clk); while (rdy !== 1'b1);
    sel <= 0;
    trans <= 2'b00;
    wdata <= {24'h0, d};
    do @(posedge clk); while (rdy !== 1'b1);
    rd = rdata;
    chk("response", 32'h0, {31'h0, resp});
  endtask
  // Waits for the next report, bounded
  task automatic rep(input logic [6:0] e);
    int n0;
    int k;
    n0 = n;
    k = 0;
    while (n == n0 && k < 20) begin
      @(posedge clk);
      k++;
    end
    chk("count", n0 + 1, n);
    chk("report", {25'h0, e}, {25'h0, got});
  endtask
  task automatic final_report;
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  initial begin
    #100000;
    mismatches++;
    final_report();
  end
  initial begin
    repeat (5) @(posedge clk);
    rst <= 0;
    @(posedge clk);
    foreach (rows[i]) begin
      bus(1, rows[i][23:16], rows[i][15:8]);
      bus(0, rows[i][23:16], 8'h00);
      chk("register", {24'h0, rows[i][7:0]}, rd);
    end
    for (int i = 0; i < 7; i++) begin
      mon <= mon ^ (7'h01 << i);
      rep(ev[i]);
      mon <= mon ^ (7'h01 << i);
      rep(i == 0 ? 7'h44 : ev[i]);
    end
    // Event during a busy bus is held
    hold <= 1;
    repeat (2) @(posedge clk);
    m = n;
    mon <= mon ^ 7'h02;
    repeat (5) @(posedge clk);
    chk("held", m, n);
    hold <= 0;
    rep(7'h01);
    rst <= 1;
    repeat (2) @(posedge clk);
    rst <= 0;
    @(posedge clk);
    bus(0, ADDR_SCRATCH, 8'h00);
    chk("scratch reset", 0, rd);
    bus(0, ADDR_PWR_CTRL, 8'h00);
    chk("enable reset", 0, rd);
    m = n;
    mon <= mon ^ 7'h7f;
    repeat (6) @(posedge clk);
    chk("quiet", m, n);
    final_report();
  end
endmodule
`default_nettype wire
